// [src/pgif_top.sv]
// power-good interrupt flags: sticky event flags, masks, register port.
// assumes power-good pins are asynchronous; enables come from clk_sys logic.
module pgif_top
  import pgif_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [3:0] buck_good,
  input wire logic [9:0] reg_good,
  input wire logic [3:0] buck_enable,
  input wire logic [3:0] reg_enable,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic irq_req
);
  // ==========================================================
  // pin synchronisers
  logic [3:0] buck_good_s;
  logic [9:0] reg_good_s;

  pgif_sync #(.WIDTH(PGIF_BUCK_N)) u_sync_buck (
    .clk_sys(clk_sys),
    .rst(rst),
    .async_in(buck_good),
    .sync_out(buck_good_s)
  );

  pgif_sync #(.WIDTH(PGIF_REG_N)) u_sync_reg (
    .clk_sys(clk_sys),
    .rst(rst),
    .async_in(reg_good),
    .sync_out(reg_good_s)
  );

  // ==========================================================
  // edge detection
  // edges are ignored until the synchronisers carry true samples, so a
  // supply already good at reset release does not raise a bogus flag.
  logic [3:0] buck_prev_q;
  logic [3:0] buck_prev_d;
  logic [9:0] reg_prev_q;
  logic [9:0] reg_prev_d;
  logic [1:0] prime_q;
  logic [1:0] prime_d;
  logic primed;
  logic [7:0] event_a;
  logic [5:0] event_b;

  always_comb begin
    buck_prev_d = buck_good_s;
    reg_prev_d = reg_good_s;
    prime_d = prime_q;
    if (prime_q != PGIF_PRIME_CYCLES) begin
      prime_d = prime_q + 2'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      buck_prev_q <= '0;
      reg_prev_q <= '0;
      prime_q <= '0;
    end else begin
      buck_prev_q <= buck_prev_d;
      reg_prev_q <= reg_prev_d;
      prime_q <= prime_d;
    end
  end

  assign primed = (prime_q == PGIF_PRIME_CYCLES);

  always_comb begin
    event_a = '0;
    event_b = '0;
    if (primed) begin
      // a drop caused by switching the supply off is not a fault
      event_a[PGIF_BUCK_LSB +: PGIF_BUCK_N] =
        buck_prev_q & ~buck_good_s & buck_enable;
      event_a[PGIF_LOWREG_LSB +: PGIF_LOWREG_N] =
        reg_prev_q[3:0] & ~reg_good_s[3:0] & reg_enable;
      event_b = reg_prev_q[9:4] ^ reg_good_s[9:4];
    end
  end

  // ==========================================================
  // flag and mask registers
  logic [7:0] flags_a_q;
  logic [7:0] flags_a_d;
  logic [7:0] mask_a_q;
  logic [7:0] mask_a_d;
  logic [5:0] flags_b_q;
  logic [5:0] flags_b_d;
  logic [7:0] mask_b_q;
  logic [7:0] mask_b_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic irq_q;
  logic irq_d;
  logic wr_flags_a;
  logic wr_flags_b;

  assign wr_flags_a = reg_wr && (reg_addr == PGIF_FLAGS_A_OFS);
  assign wr_flags_b = reg_wr && (reg_addr == PGIF_FLAGS_B_OFS);

  always_comb begin
    // a new event in the clearing cycle wins over the clear
    flags_a_d = flags_a_q | event_a;
    flags_b_d = flags_b_q | event_b;
    if (wr_flags_a) begin
      flags_a_d = (flags_a_q & ~reg_wdata) | event_a;
    end
    if (wr_flags_b) begin
      flags_b_d = (flags_b_q & ~reg_wdata[5:0]) | event_b;
    end
    mask_a_d = mask_a_q;
    mask_b_d = mask_b_q;
    if (reg_wr && (reg_addr == PGIF_MASK_A_OFS)) begin
      mask_a_d = reg_wdata;
    end
    if (reg_wr && (reg_addr == PGIF_MASK_B_OFS)) begin
      // upper two bits are kept but never read back
      mask_b_d = reg_wdata;
    end
    // request follows the next flag/mask state, so it is never a cycle late
    irq_d = |(flags_a_d & ~mask_a_d) | |(flags_b_d & ~mask_b_d[5:0]);
    rdata_d = rdata_q;
    if (reg_rd) begin
      case (reg_addr)
        PGIF_FLAGS_A_OFS: rdata_d = flags_a_q;
        PGIF_MASK_A_OFS: rdata_d = mask_a_q;
        PGIF_FLAGS_B_OFS: rdata_d = {PGIF_UNUSED_READ, flags_b_q};
        PGIF_MASK_B_OFS: rdata_d = {PGIF_UNUSED_READ, mask_b_q[5:0]};
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      flags_a_q <= PGIF_FLAGS_A_RST;
      mask_a_q <= PGIF_MASK_A_RST;
      flags_b_q <= PGIF_FLAGS_B_RST;
      mask_b_q <= PGIF_MASK_B_RST;
      rdata_q <= 8'h00;
      irq_q <= 1'b0;
    end else begin
      flags_a_q <= flags_a_d;
      mask_a_q <= mask_a_d;
      flags_b_q <= flags_b_d;
      mask_b_q <= mask_b_d;
      rdata_q <= rdata_d;
      irq_q <= irq_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign irq_req = irq_q;

  // ==========================================================
  // assertions
  sequence s_clear_a;
    wr_flags_a && (event_a == 8'h00);
  endsequence

  sequence s_clear_b;
    wr_flags_b && (event_b == 6'h00);
  endsequence

  a_low_event_set: assert property (@(posedge clk_sys) disable iff (rst)
    (event_a != 8'h00) |=> ((flags_a_q & $past(event_a)) == $past(event_a)))
    else $error("falling power-good event did not set its flag");

  a_disabled_no_set: assert property (@(posedge clk_sys) disable iff (rst)
    ##1 ((flags_a_q & ~$past(flags_a_q) & ~$past(event_a)) == 8'h00))
    else $error("first flag register set without a qualified event");

  a_enable_gates_edge: assert property (@(posedge clk_sys) disable iff (rst)
    ((event_a[PGIF_BUCK_LSB +: PGIF_BUCK_N] & ~buck_enable) == 4'h0)
    && ((event_a[PGIF_LOWREG_LSB +: PGIF_LOWREG_N] & ~reg_enable) == 4'h0))
    else $error("event accepted from a disabled supply");

  a_clear_by_one: assert property (@(posedge clk_sys) disable iff (rst)
    s_clear_a |=> ((flags_a_q & $past(reg_wdata)) == 8'h00)
      && (flags_a_q == ($past(flags_a_q) & ~$past(reg_wdata))))
    else $error("write of one did not clear exactly those flags");

  a_clear_by_one_b: assert property (@(posedge clk_sys) disable iff (rst)
    s_clear_b |=> (flags_b_q == ($past(flags_b_q) & ~$past(reg_wdata[5:0]))))
    else $error("second flag register clear wrong");

  a_flags_hold: assert property (@(posedge clk_sys) disable iff (rst)
    (!wr_flags_a && !wr_flags_b) |=> ((flags_a_q & $past(flags_a_q)) == $past(flags_a_q))
      && ((flags_b_q & $past(flags_b_q)) == $past(flags_b_q)))
    else $error("flag dropped without a clearing write");

  a_either_edge_set: assert property (@(posedge clk_sys) disable iff (rst)
    ($changed(reg_good_s[9:4]) && primed && (reg_prev_q[9:4] == $past(reg_good_s[9:4])))
      |=> ((flags_b_q & $past(reg_good_s[9:4] ^ reg_prev_q[9:4]))
        == $past(reg_good_s[9:4] ^ reg_prev_q[9:4])))
    else $error("regulator edge did not set its flag");

  a_unused_read_zero: assert property (@(posedge clk_sys) disable iff (rst)
    (reg_rd && ((reg_addr == PGIF_FLAGS_B_OFS) || (reg_addr == PGIF_MASK_B_OFS)))
      |=> (reg_rdata[7:6] == 2'h0))
    else $error("unused bits read nonzero");

  // a quiet cycle between write and read keeps a later write from changing the value
  a_mask_read_back: assert property (@(posedge clk_sys) disable iff (rst)
    (reg_wr && (reg_addr == PGIF_MASK_A_OFS)) ##1 !reg_wr
      ##1 (reg_rd && (reg_addr == PGIF_MASK_A_OFS))
      |=> (reg_rdata == $past(reg_wdata, 3)))
    else $error("first mask register did not read back");

  a_reset_values: assert property (@(posedge clk_sys)
    rst |=> (flags_a_q == 8'h00) && (mask_a_q == 8'hFF)
      && (flags_b_q == 6'h00) && (mask_b_q == 8'hFF) && !irq_req)
    else $error("register not at reset value after reset");

  a_irq_matches: assert property (@(posedge clk_sys) disable iff (rst)
    irq_req == (|(flags_a_q & ~mask_a_q) || |(flags_b_q & ~mask_b_q[5:0])))
    else $error("interrupt request disagrees with flags and masks");

  a_mask_blocks: assert property (@(posedge clk_sys) disable iff (rst)
    ((mask_a_q == 8'hFF) && (mask_b_q[5:0] == 6'h3F)) |-> !irq_req)
    else $error("request raised with every source masked");
endmodule

// [src/pgif_pkg.sv]
// power-good interrupt flags: register map, field layout and reset values.
// assumes an 8-bit register port with 8-bit offsets.
package pgif_pkg;
  // ==========================================================
  // register offsets
  localparam logic [7:0] PGIF_FLAGS_A_OFS = 8'h3D;
  localparam logic [7:0] PGIF_MASK_A_OFS = 8'h3E;
  localparam logic [7:0] PGIF_FLAGS_B_OFS = 8'h3F;
  localparam logic [7:0] PGIF_MASK_B_OFS = 8'h40;
  // ==========================================================
  // reset values
  localparam logic [7:0] PGIF_FLAGS_A_RST = 8'h00;
  localparam logic [7:0] PGIF_MASK_A_RST = 8'hFF;
  localparam logic [5:0] PGIF_FLAGS_B_RST = 6'h00;
  localparam logic [7:0] PGIF_MASK_B_RST = 8'hFF;
  // ==========================================================
  // field layout
  localparam int PGIF_BUCK_LSB = 0;
  localparam int PGIF_LOWREG_LSB = 4;
  localparam int PGIF_BUCK_N = 4;
  localparam int PGIF_LOWREG_N = 4;
  localparam int PGIF_HIGHREG_N = 6;
  localparam int PGIF_REG_N = 10;
  localparam logic [1:0] PGIF_UNUSED_READ = 2'h0;
  // cycles until the pin synchronisers and the previous-sample registers hold real samples after reset
  localparam logic [1:0] PGIF_PRIME_CYCLES = 2'h3;
endpackage

// [src/pgif_sync.sv]
// two-stage synchroniser for a bundle of asynchronous level inputs.
// assumes every bit is a slow level; no bit-to-bit coherence is given.
module pgif_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;
endmodule

// [verification/pgif_host.sv]
// host software model: single-byte reads and writes over the strobe port.
// assumes reg_rdata is registered and valid one cycle after the read strobe.
module pgif_host (
  input wire logic clk_sys,
  input wire logic [7:0] reg_rdata,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  output logic reg_rd
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
  end
  // ==========================================================
  // access tasks
  // write data is inverted once released so a stale byte is never mistaken for a hold
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(negedge clk_sys);
    reg_addr = addr;
    reg_wdata = data;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    reg_wdata = ~data;
  endtask
  task automatic rd(input logic [7:0] addr, output logic [7:0] data);
    @(negedge clk_sys);
    reg_addr = addr;
    reg_rd = 1'b1;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    data = reg_rdata;
  endtask
endmodule

// [verification/test_power_good_interrupt_flags.sv]
// self-checking bench for the power-good interrupt flags block.
// assumes pgif_host drives the register port; pins change at the falling edge.
module test_power_good_interrupt_flags
  import pgif_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [3:0] buck_good = 4'hF;
  logic [9:0] reg_good = 10'h3FF;
  logic [3:0] buck_enable = 4'hF;
  logic [3:0] reg_enable = 4'hF;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic reg_wr;
  logic reg_rd;
  logic irq_req;
  int n_mismatch = 0;
  int checks = 0;
  always #25 clk_sys = ~clk_sys;
  pgif_top dut (.clk_sys(clk_sys), .rst(rst), .buck_good(buck_good), .reg_good(reg_good),
    .buck_enable(buck_enable), .reg_enable(reg_enable), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_req(irq_req));
  pgif_host host (.clk_sys(clk_sys), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd));
  // ==========================================================
  // checking helpers
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rdchk(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] v;
    host.rd(addr, v);
    check(v, exp);
  endtask
  // the registered request changes on the same edge as the register update; one spare cycle passes before it is sampled
  task automatic irqchk(input logic exp);
    @(negedge clk_sys);
    check({7'h00, irq_req}, {7'h00, exp});
  endtask
  // synchroniser plus edge detect take three cycles to set a flag
  task automatic settle();
    repeat (6) @(negedge clk_sys);
  endtask
  task automatic test_done();
    if (n_mismatch == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ==========================================================
  // watchdog: the sequence needs about 130 cycles, this allows 2000
  initial begin
    #100000;
    n_mismatch++;
    test_done();
  end
  // ==========================================================
  // main sequence
  initial begin
    repeat (16) @(negedge clk_sys);
    rst = 1'b0;
    rdchk(PGIF_FLAGS_A_OFS, 8'h00);
    rdchk(PGIF_MASK_A_OFS, 8'hFF);
    rdchk(PGIF_FLAGS_B_OFS, 8'h00);
    rdchk(PGIF_MASK_B_OFS, 8'h3F);
    rdchk(8'h41, 8'h00);
    irqchk(1'b0);
    host.wr(PGIF_MASK_A_OFS, 8'h00);
    rdchk(PGIF_MASK_A_OFS, 8'h00);
    buck_good = 4'h0;
    reg_good[3:0] = 4'h0;
    settle();
    rdchk(PGIF_FLAGS_A_OFS, 8'hFF);
    irqchk(1'b1);
    host.wr(PGIF_FLAGS_A_OFS, 8'h00);
    rdchk(PGIF_FLAGS_A_OFS, 8'hFF);
    host.wr(PGIF_FLAGS_A_OFS, 8'h5A);
    rdchk(PGIF_FLAGS_A_OFS, 8'hA5);
    host.wr(PGIF_FLAGS_A_OFS, 8'hA5);
    buck_good = 4'hF;
    reg_good[3:0] = 4'hF;
    settle();
    rdchk(PGIF_FLAGS_A_OFS, 8'h00);
    irqchk(1'b0);
    // only enabled supplies may flag a drop
    buck_enable = 4'h5;
    reg_enable = 4'hA;
    buck_good = 4'h0;
    reg_good[3:0] = 4'h0;
    settle();
    rdchk(PGIF_FLAGS_A_OFS, 8'hA5);
    buck_good = 4'hF;
    reg_good[3:0] = 4'hF;
    buck_enable = 4'hF;
    reg_enable = 4'hF;
    settle();
    host.wr(PGIF_FLAGS_A_OFS, 8'hFF);
    reg_good[9:4] = 6'h00;
    settle();
    rdchk(PGIF_FLAGS_B_OFS, 8'h3F);
    irqchk(1'b0);
    host.wr(PGIF_FLAGS_B_OFS, 8'h3F);
    reg_good[9:4] = 6'h3F;
    settle();
    rdchk(PGIF_FLAGS_B_OFS, 8'h3F);
    host.wr(PGIF_MASK_B_OFS, 8'hDF);
    irqchk(1'b1);
    host.wr(PGIF_MASK_B_OFS, 8'hFF);
    irqchk(1'b0);
    rdchk(PGIF_MASK_B_OFS, 8'h3F);
    host.wr(PGIF_FLAGS_B_OFS, 8'hFF);
    rdchk(PGIF_FLAGS_B_OFS, 8'h00);
    // a masked event still latches its flag
    host.wr(PGIF_MASK_A_OFS, 8'hFF);
    buck_good[0] = 1'b0;
    settle();
    rdchk(PGIF_FLAGS_A_OFS, 8'h01);
    irqchk(1'b0);
    host.wr(PGIF_MASK_A_OFS, 8'hFE);
    irqchk(1'b1);
    rst = 1'b1;
    repeat (2) @(negedge clk_sys);
    rst = 1'b0;
    rdchk(PGIF_FLAGS_A_OFS, 8'h00);
    rdchk(PGIF_MASK_A_OFS, 8'hFF);
    rdchk(PGIF_MASK_B_OFS, 8'h3F);
    irqchk(1'b0);
    test_done();
  end
endmodule
